// >>> logic/flash_port_cfg.svh
// Offsets, field positions, reset values and counts of the flash serial port
`ifndef FLASH_PORT_CFG_SVH
`define FLASH_PORT_CFG_SVH

`define AXI_ADDR_W      8
`define REG_CFG_OFS     8'h00
`define REG_FUNC_OFS    8'h04
`define REG_STATUS_OFS  8'h08
`define REG_RXDATA_OFS  8'h0C
`define REG_TXDATA_OFS  8'h10

`define CFG_W           5
`define CFG_RESET       5'h00
`define FUNC_RESET      1'h0
`define FUNC_DIS_BIT    0
`define ST_OVR_BIT      3
`define RX_VALID_BIT    8

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define RX_FIFO_DEPTH   8
`define BYTE_BITS       4'h8
`define TX_IDLE_BYTE    8'hFF

`endif

// >>> logic/flash_port_pkg.sv
// Types shared by the flash serial port modules
package flash_port_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE,
    LANE_DUAL,
    LANE_QUAD,
    LANE_CMD4
  } lane_mode_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_WAIT_HIGH,
    ST_READY,
    ST_FRAME
  } link_state_t;

  // Field order matches the configuration register bits 4..0
  typedef struct packed {
    logic       drive;
    lane_mode_t mode;
    logic       shared_pin_role_select;
    logic       quad_lanes_enable_bit;
  } cfg_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       restart_n;
    logic [3:0] lanes;
  } pins_t;

endpackage

// >>> logic/byte_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  output logic [CW-1:0]         level
);
  // DEPTH must be a power of two so the pointers wrap for free
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             do_wr, do_rd;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;

  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_d  = do_wr ? wr_q + AW'(1) : wr_q;
    rd_d  = do_rd ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + CW'(do_wr) - CW'(do_rd);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      if (do_wr) begin
        mem[wr_q] <= in_data;
      end
    end
  end
endmodule

// >>> logic/flash_serial_port.sv
// Flash serial port front end: lane modes, pause and restart pins, AXI4-Lite registers
// Contract
// RL1 - Restart input high: device runs normally and takes bus traffic.
// RL2 - Restart input low: device held in reset, all lanes floated.
// RL3 - Master avoids restart during internal write, program or erase.
// RL4 - Function register bit zero set turns the dedicated restart input off.
// RL5 - Shared pin role selectable only with quad lanes off and dedicated restart off.
// RL6 - When sharing, role select zero means pause, one means restart.
// RL7 - Clock modes 0 and 3 both work; master uses one of them.
// RL8 - Master parks clock low in mode 0, high in mode 3.
// RL9 - Incoming bits sampled on rising serial clock edge.
// RL10 - Outgoing bits launched from falling serial clock edge.
// RL11 - Dual operation: input and output pins become lanes zero and one.
// RL12 - Quad operation: four pins become lanes zero to three.
// RL13 - Select high: deselected, outputs floated, incoming data ignored.
// RL14 - Pause low while selected: outputs float, sequence kept until release.
// RL15 - Quad enable set: shared pin is lane three, no pause or restart.
// RL16 - After power-up select must go high to low before a transfer.
// RL17 - Bytes move most significant bit first on every lane width.
// RL18 - Leaving reset drops partial bytes and waits for a fresh select fall.
`timescale 1ns/1ns
`include "flash_port_cfg.svh"
module flash_serial_port #(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic                  sclk_pin,
  input  wire logic                  cs_n_pin,
  input  wire logic                  restart_n_pin,
  input  wire logic [3:0]            lane_in,
  output logic      [3:0]            lane_out,
  output logic      [3:0]            lane_oe,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  flash_port_pkg::pins_t pin_s1_q, pin_s2_q, pin_p_q;
  logic sck_rise, sck_fall, cs_s, cs_fall, l3_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '{sclk: 1'b0, cs_n: 1'b1, restart_n: 1'b1, lanes: 4'hF};
      pin_s2_q <= '{sclk: 1'b0, cs_n: 1'b1, restart_n: 1'b1, lanes: 4'hF};
      pin_p_q  <= '{sclk: 1'b0, cs_n: 1'b1, restart_n: 1'b1, lanes: 4'hF};
    end else if (ce) begin
      pin_s1_q <= '{sclk: sclk_pin, cs_n: cs_n_pin, restart_n: restart_n_pin, lanes: lane_in};
      pin_s2_q <= pin_s1_q;
      pin_p_q  <= pin_s2_q;
    end
  end

  // Edges are found on the second stage so the first stays metastability-only
  assign sck_rise = pin_s2_q.sclk && !pin_p_q.sclk;
  assign sck_fall = !pin_s2_q.sclk && pin_p_q.sclk;
  assign cs_s     = pin_s2_q.cs_n;
  assign cs_fall  = !pin_s2_q.cs_n && pin_p_q.cs_n;
  assign l3_s     = pin_s2_q.lanes[3];

  ////////////////////////////////////////////////////////////////////////////
  // Pin role selection
  flash_port_pkg::cfg_t cfg_q, cfg_d;
  logic func_dis_q, func_dis_d;
  logic share_ok, restart_act, pause_act;

  assign share_ok    = !cfg_q.quad_lanes_enable_bit && func_dis_q; // RL5
  assign restart_act = (!func_dis_q && !pin_s2_q.restart_n) ||     // RL4 RL1 RL2
                       (share_ok && cfg_q.shared_pin_role_select && !l3_s); // RL6
  assign pause_act   = !cfg_q.quad_lanes_enable_bit &&             // RL15
                       (!func_dis_q || !cfg_q.shared_pin_role_select) && !l3_s && !cs_s; // RL14 RL6

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  function automatic logic [3:0] lane_bits(input flash_port_pkg::cfg_t c);
    case (c.mode)
      flash_port_pkg::LANE_DUAL: lane_bits = 4'h2; // RL11
      flash_port_pkg::LANE_QUAD,
      flash_port_pkg::LANE_CMD4: lane_bits = c.quad_lanes_enable_bit ? 4'h4 : 4'h1; // RL12
      default: lane_bits = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [3:0] l, input logic [3:0] n);
    case (n)
      4'h2: shift_in = {v[5:0], l[1:0]};
      4'h4: shift_in = {v[3:0], l};
      default: shift_in = {v[6:0], l[0]};
    endcase
  endfunction

  flash_port_pkg::link_state_t st_q, st_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d, tx_hold_q, tx_hold_d;
  logic [3:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d, nb;
  logic [3:0] lane_out_q, lane_out_d, lane_oe_q, lane_oe_d;
  logic       rose_q, rose_d, push, tx_take, tx_full_q, tx_full_d, oe_en;
  logic       fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic [CW-1:0] fifo_level;

  assign nb = lane_bits(cfg_q);

  always_comb begin
    st_d     = st_q;
    rx_d     = rx_q;
    rx_cnt_d = rx_cnt_q;
    tx_d     = tx_q;
    tx_cnt_d = tx_cnt_q;
    rose_d   = rose_q;
    push     = 1'b0;
    tx_take  = 1'b0;
    case (st_q)
      flash_port_pkg::ST_RESET: begin
        if (!restart_act) begin
          st_d = flash_port_pkg::ST_WAIT_HIGH; // RL18
        end
      end
      flash_port_pkg::ST_WAIT_HIGH: begin
        if (cs_s) begin
          st_d = flash_port_pkg::ST_READY; // RL16
        end
      end
      flash_port_pkg::ST_READY: begin
        if (cs_fall) begin
          st_d     = flash_port_pkg::ST_FRAME;
          rx_cnt_d = 4'h0;
          tx_cnt_d = 4'h0;
          rose_d   = 1'b0;
          tx_d     = tx_full_q ? tx_hold_q : `TX_IDLE_BYTE;
          tx_take  = tx_full_q;
        end
      end
      flash_port_pkg::ST_FRAME: begin
        if (cs_s) begin
          st_d = flash_port_pkg::ST_READY; // RL13
        end else if (!pause_act) begin // RL14
          if (sck_rise) begin // RL9 RL7
            rx_d   = shift_in(rx_q, pin_s2_q.lanes, nb); // RL17
            rose_d = 1'b1;
            if (rx_cnt_q + nb == `BYTE_BITS) begin
              rx_cnt_d = 4'h0;
              push     = 1'b1;
            end else begin
              rx_cnt_d = rx_cnt_q + nb;
            end
          end
          // Mode 3 opens with a fall that precedes any data bit
          if (sck_fall && rose_q) begin // RL10 RL7
            if (tx_cnt_q + nb == `BYTE_BITS) begin
              tx_cnt_d = 4'h0;
              tx_d     = tx_full_q ? tx_hold_q : `TX_IDLE_BYTE;
              tx_take  = tx_full_q;
            end else begin
              tx_cnt_d = tx_cnt_q + nb;
              tx_d     = tx_q << nb; // RL17
            end
          end
        end
      end
      default: st_d = flash_port_pkg::ST_RESET;
    endcase
    if (restart_act) begin // RL2 RL18
      st_d     = flash_port_pkg::ST_RESET;
      rx_cnt_d = 4'h0;
      tx_cnt_d = 4'h0;
      rose_d   = 1'b0;
    end
    oe_en = (st_d == flash_port_pkg::ST_FRAME) && cfg_q.drive && !pause_act && !cs_s; // RL13 RL14
    case (nb)
      4'h2: begin
        lane_oe_d  = oe_en ? 4'h3 : 4'h0; // RL11
        lane_out_d = {2'h0, tx_d[7:6]};
      end
      4'h4: begin
        lane_oe_d  = oe_en ? 4'hF : 4'h0; // RL12
        lane_out_d = tx_d[7:4];
      end
      default: begin
        lane_oe_d  = oe_en ? 4'h2 : 4'h0;
        lane_out_d = {2'h0, tx_d[7], 1'b0};
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= flash_port_pkg::ST_WAIT_HIGH;
      rx_q       <= 8'h00;
      rx_cnt_q   <= 4'h0;
      tx_q       <= 8'h00;
      tx_cnt_q   <= 4'h0;
      rose_q     <= 1'b0;
      lane_out_q <= 4'h0;
      lane_oe_q  <= 4'h0;
    end else if (ce) begin
      st_q       <= st_d;
      rx_q       <= rx_d;
      rx_cnt_q   <= rx_cnt_d;
      tx_q       <= tx_d;
      tx_cnt_q   <= tx_cnt_d;
      rose_q     <= rose_d;
      lane_out_q <= lane_out_d;
      lane_oe_q  <= lane_oe_d;
    end
  end

  assign lane_out = lane_out_q;
  assign lane_oe  = lane_oe_q;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (push),
    .in_data   (rx_d),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave
  logic [`AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d, wa, ra;
  logic [31:0] wdat_q, wdat_d, rdata_q, rdata_d;
  logic        wstrb0_q, wstrb0_d, aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d, ovr_q, ovr_d, ovr_clr;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

  always_comb begin
    aw_addr_d = aw_addr_q;
    wdat_d    = wdat_q;
    wstrb0_d  = wstrb0_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    cfg_d     = cfg_q;
    func_dis_d = func_dis_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q && !tx_take;
    ovr_clr   = 1'b0;
    fifo_pop  = 1'b0;
    wa        = {aw_addr_q[`AXI_ADDR_W-1:2], 2'h0};
    ra        = {araddr[`AXI_ADDR_W-1:2], 2'h0};
    if (awvalid && awready_q) begin
      aw_addr_d = awaddr;
      aw_have_d = 1'b1;
    end
    if (wvalid && wready_q) begin
      wdat_d   = wdata;
      wstrb0_d = wstrb[0];
      w_have_d = 1'b1;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (wa)
        `REG_CFG_OFS:    if (wstrb0_q) cfg_d = flash_port_pkg::cfg_t'(wdat_q[`CFG_W-1:0]);
        `REG_FUNC_OFS:   if (wstrb0_q) func_dis_d = wdat_q[`FUNC_DIS_BIT];
        `REG_STATUS_OFS: ovr_clr = wstrb0_q && wdat_q[`ST_OVR_BIT];
        `REG_TXDATA_OFS: begin
          if (wstrb0_q) begin
            tx_hold_d = wdat_q[7:0];
            tx_full_d = 1'b1;
          end
        end
        `REG_RXDATA_OFS: ;
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (ra)
        `REG_CFG_OFS:    rdata_d = 32'(cfg_q);
        `REG_FUNC_OFS:   rdata_d = 32'(func_dis_q);
        `REG_STATUS_OFS: rdata_d = 32'({fifo_level, ovr_q, st_q == flash_port_pkg::ST_RESET, pause_act,
                                        st_q == flash_port_pkg::ST_FRAME});
        `REG_RXDATA_OFS: begin
          // Reading pops the byte; an empty read shows valid low
          rdata_d  = 32'({fifo_out_valid, fifo_out_valid ? fifo_out_data : 8'h00});
          fifo_pop = fifo_out_valid;
        end
        `REG_TXDATA_OFS: rdata_d = 32'(tx_hold_q);
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    // Overrun: a byte lost to a full FIFO, set beats clear
    ovr_d     = (ovr_q && !ovr_clr) || (push && !fifo_in_ready);
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q  <= '0;
      wdat_q     <= 32'h0000_0000;
      wstrb0_q   <= 1'b0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      arready_q  <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= `RESP_OKAY;
      rdata_q    <= 32'h0000_0000;
      cfg_q      <= flash_port_pkg::cfg_t'(`CFG_RESET);
      func_dis_q <= `FUNC_RESET;
      tx_hold_q  <= 8'h00;
      tx_full_q  <= 1'b0;
      ovr_q      <= 1'b0;
    end else if (ce) begin
      aw_addr_q  <= aw_addr_d;
      wdat_q     <= wdat_d;
      wstrb0_q   <= wstrb0_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      arready_q  <= arready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      cfg_q      <= cfg_d;
      func_dis_q <= func_dis_d;
      tx_hold_q  <= tx_hold_d;
      tx_full_q  <= tx_full_d;
      ovr_q      <= ovr_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reset_exit;
    (st_q == flash_port_pkg::ST_RESET) ##1 (st_q != flash_port_pkg::ST_RESET);
  endsequence

  sequence s_single_rise;
    ce && sck_rise && (st_q == flash_port_pkg::ST_FRAME) && !cs_s && !pause_act && !restart_act && (nb == 4'h1);
  endsequence

  AST_RESET_FLOAT: assert property (ce && restart_act |=> lane_oe_q == 4'h0 && st_q == flash_port_pkg::ST_RESET) // RL2
    else $error("lanes driven or engine running while restart held");
  AST_DESELECT_FLOAT: assert property (ce && cs_s |=> lane_oe_q == 4'h0 && st_q != flash_port_pkg::ST_FRAME) // RL13
    else $error("lanes driven while deselected");
  AST_PAUSE_FLOAT: assert property (ce && pause_act |=> lane_oe_q == 4'h0) // RL14
    else $error("lanes driven during pause");
  AST_PAUSE_KEEPS: assert property (ce && pause_act && !restart_act && st_q == flash_port_pkg::ST_FRAME
                                    |=> rx_cnt_q == $past(rx_cnt_q) && rx_q == $past(rx_q)) // RL14
    else $error("receive sequence disturbed during pause");
  AST_QUAD_NO_PIN_ROLE: assert property (cfg_q.quad_lanes_enable_bit && pin_s2_q.restart_n |-> !pause_act && !restart_act) // RL15
    else $error("shared pin acted as pause or restart with quad lanes on");
  AST_DEDICATED_OFF: assert property (func_dis_q && !pin_s2_q.restart_n && l3_s |-> !restart_act) // RL4
    else $error("restart acted with dedicated input disabled");
  AST_SHARED_RESTART: assert property (ce && share_ok && cfg_q.shared_pin_role_select && !l3_s
                                       |=> st_q == flash_port_pkg::ST_RESET) // RL6
    else $error("shared pin in restart role did not reset");
  AST_FRESH_SELECT: assert property (s_reset_exit |-> st_q == flash_port_pkg::ST_WAIT_HIGH) // RL18
    else $error("reset exit did not wait for select high");
  AST_MSB_FIRST: assert property (s_single_rise |=> rx_q == {$past(rx_q[6:0]), $past(pin_s2_q.lanes[0])}) // RL17
    else $error("single lane receive not msb first");
  AST_LAUNCH_FALL: assert property (st_q == flash_port_pkg::ST_FRAME && $past(st_q) == flash_port_pkg::ST_FRAME
                                    && tx_cnt_q != $past(tx_cnt_q) |-> $past(sck_fall)) // RL10
    else $error("output bit advanced without falling edge");
endmodule

// >>> bench/spi_master_model.sv
// Behavioural serial master that drives the flash port pins
`timescale 1ns/1ns
module spi_master_model (
  input  wire logic       aclk,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe,
  input  wire logic       l3_lvl,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      lane_in
);
  logic [3:0] drv;
  logic [3:0] men;
  logic [3:0] oe_seen;

  // Released lanes fall back to board pull-ups; lane 3 level is set by the bench
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = lane_oe[i] ? lane_out[i] : men[i] ? drv[i] : (i == 3) ? l3_lvl : 1'b1;
    end
  end

  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    drv     = 4'hF;
    men     = 4'h0;
    oe_seen = 4'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Half period of 8 aclk gives the 160 ns link clock
  task automatic xfer(input logic [7:0] tx, input int w, input bit m3, input int steps,
                      input logic [3:0] en, output logic [7:0] rx);
    logic [7:0] sh;
    sh      = tx;
    rx      = 8'h00;
    oe_seen = 4'h0;
    @(posedge aclk);
    sclk <= m3;
    wt(8);
    cs_n <= 1'b0;
    men  <= en;
    for (int s = 0; s < steps; s++) begin
      wt(8);
      sclk <= 1'b0;
      drv  <= (w == 1) ? {3'b111, sh[7]} : (w == 2) ? {2'b11, sh[7:6]} : sh[7:4];
      sh   = sh << w;
      wt(8);
      rx      = (w == 1) ? {rx[6:0], lane_in[1]} : (w == 2) ? {rx[5:0], lane_in[1:0]} : {rx[3:0], lane_in};
      oe_seen = oe_seen | lane_oe;
      sclk   <= 1'b1;
    end
    wt(8);
    sclk <= m3;
    wt(8);
    cs_n <= 1'b1;
    men  <= 4'h0;
    wt(8);
  endtask
endmodule

// >>> bench/flash_serial_port_tb_top.sv
// Self-checking bench for the flash serial port
`timescale 1ns/1ns
`include "flash_port_cfg.svh"
module flash_serial_port_tb_top;
  logic                   aclk = 1'b0;
  logic                   aresetn;
  logic                   restart_n_pin;
  logic                   l3_lvl;
  logic                   sclk;
  logic                   cs_n;
  logic [3:0]             lane_in;
  logic [3:0]             lane_out;
  logic [3:0]             lane_oe;
  logic [`AXI_ADDR_W-1:0] awaddr;
  logic [`AXI_ADDR_W-1:0] araddr;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic [1:0]             bresp;
  logic [1:0]             rresp;
  int                     error_cnt = 0;
  int                     n_checks = 0;

  always #5 aclk = ~aclk;

  flash_serial_port dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .sclk_pin(sclk), .cs_n_pin(cs_n),
    .restart_n_pin(restart_n_pin), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  spi_master_model mdl (
    .aclk(aclk), .lane_out(lane_out), .lane_oe(lane_oe), .l3_lvl(l3_lvl),
    .sclk(sclk), .cs_n(cs_n), .lane_in(lane_in)
  );

  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [`AXI_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    bit done;
    n    = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
      end
    end while (!done && n < 100);
    if (!done) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic rd(input logic [`AXI_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n    = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end while (!done && n < 100);
    if (!done) begin
      error_cnt++;
      conclude();
    end
  endtask

  function automatic logic [3:0] lanes(input int w);
    return (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
  endfunction

  // One full single-lane byte, then the received word is read back
  task automatic byte_in(input logic [31:0] exp_rx, input logic [31:0] exp_st);
    logic [7:0]  y;
    logic [31:0] d;
    logic [1:0]  r;
    mdl.xfer(8'h5A, 1, 1'b0, 8, 4'h1, y);
    rd(`REG_RXDATA_OFS, d, r);
    chk(d, exp_rx);
    rd(`REG_STATUS_OFS, d, r);
    chk(d, exp_st);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  t;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  q[8];
    logic [3:0]  en;
    int          w;
    aresetn       = 1'b0;
    restart_n_pin = 1'b1;
    l3_lvl        = 1'b1;
    awaddr        = 8'h00;
    araddr        = 8'h00;
    wdata         = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    void'($urandom(40));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      rd(8'(a * 4), d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, 32'h0);
    end
    rd(8'h20, d, r);
    chk({d[31:2], r}, 32'h2);
    wr(8'h20, 32'h0);
    chk({30'h0, bresp}, 32'h2);
    // Every lane mode, receive only and with the device driving
    for (int m = 0; m < 8; m++) begin
      w = (m % 4 == 0) ? 1 : (m % 4 == 1) ? 2 : 4;
      t = 8'($urandom);
      x = 8'($urandom);
      wr(`REG_CFG_OFS, {27'h0, m[2], m[1:0], 1'b0, m[1]});
      wr(`REG_TXDATA_OFS, {24'h0, t});
      en = (m[2] && w > 1) ? 4'h0 : lanes(w);
      mdl.xfer(x, w, m[0], 8 / w, en, y);
      if (m[2]) chk({24'h0, y}, {24'h0, t});
      chk({28'h0, mdl.oe_seen}, {28'h0, m[2] ? ((w == 1) ? 4'h2 : lanes(w)) : 4'h0});
      chk({28'h0, lane_oe}, 32'h0);
      rd(`REG_RXDATA_OFS, d, r);
      chk(d, {23'h0, 1'b1, (m[2] && w > 1) ? t : x});
    end
    // Fill the FIFO past full, then drain it with the master idle
    wr(`REG_CFG_OFS, 32'h0);
    for (int i = 0; i < 9; i++) begin
      x = 8'($urandom);
      if (i < 8) q[i] = x;
      mdl.xfer(x, 1, i[0], 8, 4'h1, y);
    end
    rd(`REG_STATUS_OFS, d, r);
    chk(d, 32'h88);
    wr(`REG_STATUS_OFS, 32'h8);
    chk({30'h0, bresp}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(`REG_RXDATA_OFS, d, r);
      chk(d, {23'h0, 1'b1, q[i]});
    end
    byte_in(32'h15A, 32'h0);
    // Partial byte is dropped at deselect
    mdl.xfer(8'hC3, 1, 1'b0, 4, 4'h1, y);
    byte_in(32'h15A, 32'h0);
    wr(`REG_CFG_OFS, 32'h10);
    // No internal write runs here, so restart is safe
    restart_n_pin <= 1'b0;
    byte_in(32'h0, 32'h4);
    chk({28'h0, mdl.oe_seen}, 32'h0);
    restart_n_pin <= 1'b1;
    byte_in(32'h15A, 32'h0);
    wr(`REG_FUNC_OFS, 32'h1);
    restart_n_pin <= 1'b0;
    byte_in(32'h15A, 32'h0);
    restart_n_pin <= 1'b1;
    l3_lvl        <= 1'b0;
    wr(`REG_CFG_OFS, 32'h2);
    byte_in(32'h0, 32'h4);
    wr(`REG_CFG_OFS, 32'h0);
    byte_in(32'h0, 32'h0);
    // Dedicated restart on: role one must still mean pause
    wr(`REG_FUNC_OFS, 32'h0);
    wr(`REG_CFG_OFS, 32'h2);
    fork
      byte_in(32'h0, 32'h0);
      begin
        repeat (40) @(posedge aclk);
        rd(`REG_STATUS_OFS, d, r);
        chk(d, 32'h3);
      end
    join
    l3_lvl <= 1'b1;
    byte_in(32'h15A, 32'h0);
    conclude();
  end
endmodule
